// ### inc/slp_pkg.sv
package slp_pkg;
  // clock and derived timing
  localparam int CLK_MHZ = 125;
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int RDY_DELAY_US = 2000;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] SYNC_LAST = 12'h0002;

  // strap channels, in conversion order
  localparam int NCH = 9;
  localparam int CH_W = 4;
  localparam logic [CH_W-1:0] CH_DRV = 4'h0;
  localparam logic [CH_W-1:0] CH_GFX_IMAX = 4'h1;
  localparam logic [CH_W-1:0] CH_CORE_IMAX = 4'h2;
  localparam logic [CH_W-1:0] CH_ONTIME = 4'h3;
  localparam logic [CH_W-1:0] CH_ADDR = 4'h4;
  localparam logic [CH_W-1:0] CH_BOOST_CORE = 4'h5;
  localparam logic [CH_W-1:0] CH_BOOST_GFX = 4'h6;
  localparam logic [CH_W-1:0] CH_BOOT = 4'h7;
  localparam logic [CH_W-1:0] CH_VIN = 4'h8;
  localparam logic [NCH-1:0] SRC_MASK = 9'h0ff;

  // phase pin positions
  localparam int NPH = 7;
  localparam int PIN_GFX1 = 4;
  localparam int PIN_GFX3 = 6;

  // register map and codes
  localparam logic [7:0] REG_MAX_CUR = 8'h21;
  localparam logic [7:0] CODE_FULL = 8'hff;
  localparam logic [7:0] ADDR_LO = 8'h88;
  localparam logic [7:0] ADDR_HI = 8'h8a;

  // strap band thresholds, one code per kilohm
  localparam logic [7:0] DRV_SPLIT = 8'h0f;
  localparam logic [7:0] LATCH_BAND_MAX = 8'h64;
  localparam logic [7:0] ADDR_43_SPLIT = 8'h96;
  localparam logic [7:0] ADDR_52_SPLIT = 8'h1b;
  localparam logic [55:0] BOOT_THR = 56'hd6_9974_4624_1a13;
  localparam logic [103:0] BOOST_THR = 104'he0_d0bf_b0a2_9281_7161_5040_3020;
  localparam int BOOST_STEP_MV = 15;
  localparam int ONTIME_SCALE = 100;
  localparam int BOOT_LV_MAX = 3;

  typedef enum logic [1:0] {CFG_4P3, CFG_4P2, CFG_5P2, CFG_6P1} slp_cfg_e;
  typedef enum {ST_SYNC, ST_SENSE, ST_SETTLE, ST_CONV, ST_WAIT, ST_DONE} slp_state_e;
endpackage

// ### tb/slp_strap_model.sv
`timescale 1ns/10ps
`default_nettype none
// strap resistors on the phase pins plus the converter that reads them
module slp_strap_model
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // conversion request from the loader
  input  wire logic        adc_start,
  input  wire logic [3:0]  adc_chan,
  input  wire logic [8:0]  cur_src_on,
  input  wire logic        boot_from_pos_sense,
  // strap kilohms per channel; nine bits so a strap can exceed full scale
  input  wire logic [80:0] strap_kohm,
  input  wire logic [8:0]  alt_boot_kohm,
  input  wire logic [3:0]  delay,
  // converter answer
  output logic             adc_done,
  output logic [7:0]       adc_code,
  output logic             adc_over
);
  logic [3:0] wait_cnt;
  logic       busy;
  logic [8:0] pin_kohm;
  logic [8:0] volts;

  // in 4+2 the boot resistor sits on the graphics phase-three positive sense pin
  assign pin_kohm = (adc_chan == 4'h7 && boot_from_pos_sense) ? alt_boot_kohm
                    : strap_kohm[adc_chan*9 +: 9];
  // attached drivers stay high impedance, so only the resistor loads the pin
  assign volts = (cur_src_on[adc_chan] || adc_chan == 4'h8) ? pin_kohm : 9'h000;

  // code is valid only with done; while idle it toggles so nothing stale passes
  always_ff @(posedge ref_clk)
  begin
    adc_done <= 1'b0;
    if (rst)
    begin
      busy     <= 1'b0;
      wait_cnt <= 4'h0;
      adc_code <= 8'h00;
      adc_over <= 1'b0;
    end
    else if (adc_start)
    begin
      busy     <= 1'b1;
      wait_cnt <= delay;
    end
    else if (busy && wait_cnt == 4'h0)
    begin
      busy     <= 1'b0;
      adc_done <= 1'b1;
      adc_code <= volts[7:0];
      adc_over <= volts[8];
    end
    else if (busy)
      wait_cnt <= wait_cnt - 4'h1;
    else
    begin
      adc_code <= ~adc_code;
      adc_over <= ~adc_over;
    end
  end
endmodule
`default_nettype wire

// ### tb/strap_parameter_loader_test.sv
`timescale 1ns/10ps
`default_nettype none
module strap_parameter_loader_test;
  import slp_pkg::*;
  localparam int RDY = 20;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        en_in = 1'b1;
  logic        supply_ok = 1'b1;
  logic        reg_rd = 1'b0;
  logic        reg_rail = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [6:0]  neg_s = 7'h00;
  logic [6:0]  pos_s = 7'h7f;
  logic [6:0]  pwm_in = 7'h00;
  logic [80:0] straps = '0;
  logic [8:0]  alt_boot = 9'h000;
  logic [3:0]  delay = 4'h1;
  logic        adc_start, adc_done, adc_over, boot_pos, drv_en, ready, done, ocp;
  logic        boot_1v05, core_ext, gfx_ext, reg_ack;
  logic [3:0]  adc_chan, core_en;
  logic [2:0]  gfx_en;
  logic [8:0]  src;
  logic [7:0]  adc_code, core_max, gfx_max, vin_code, dev_addr, core_bst, gfx_bst, rdata;
  logic [6:0]  ph_out, ph_oe;
  logic [15:0] ontime;
  slp_cfg_e    phase_cfg;
  int          errors = 0;
  int          total_checks = 0;
  int          k;

  slp_strap_loader #(.RDY_CYC(RDY)) dut (
    .ref_clk(ref_clk), .rst(rst), .en_in(en_in), .supply_ok(supply_ok),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_code(adc_code), .adc_over(adc_over), .cur_src_on(src),
    .boot_from_pos_sense(boot_pos), .phase_neg_sense(neg_s), .phase_pos_sense(pos_s),
    .pwm_in(pwm_in), .phase_strap_out(ph_out), .phase_strap_oe(ph_oe),
    .driver_enable_out(drv_en), .regulator_ready(ready), .straps_done(done),
    .core_max_cur(core_max), .gfx_max_cur(gfx_max), .ontime_kohm_x100(ontime),
    .vin_code(vin_code), .ocp_current_limit(ocp), .dev_addr(dev_addr),
    .phase_cfg(phase_cfg), .core_ph_en(core_en), .gfx_ph_en(gfx_en),
    .boot_1v05(boot_1v05), .core_ext_en(core_ext), .gfx_ext_en(gfx_ext),
    .core_boost_mv(core_bst), .gfx_boost_mv(gfx_bst), .reg_rd(reg_rd),
    .reg_rail(reg_rail), .reg_addr(reg_addr), .reg_ack(reg_ack), .reg_rdata(rdata));

  slp_strap_model model (
    .ref_clk(ref_clk), .rst(rst), .adc_start(adc_start), .adc_chan(adc_chan),
    .cur_src_on(src), .boot_from_pos_sense(boot_pos), .strap_kohm(straps),
    .alt_boot_kohm(alt_boot), .delay(delay), .adc_done(adc_done),
    .adc_code(adc_code), .adc_over(adc_over));

  // 125 MHz clock
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one read on the register port; ack is due on the edge after the request
  task automatic reg_read(input logic rail, input logic [7:0] addr, exp, input string msg);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_rail <= rail;
    reg_addr <= addr;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_ack === 1'b1 && rdata === exp, msg);
  endtask

  // reset, then the whole setting period; nine channels, each settling for 2500 cycles before its conversion
  task automatic run_setting(input logic [80:0] s, input logic [6:0] n, p);
    int w;
    @(posedge ref_clk);
    straps <= s;
    neg_s  <= n;
    pos_s  <= p;
    rst    <= 1'b1;
    cyc(9);
    #1 chk(dev_addr === ADDR_LO && core_en === 4'h1 && gfx_en === 3'h1 && done === 1'b0, "reset");
    cyc(1);
    rst <= 1'b0;
    reg_read(1'b0, REG_MAX_CUR, 8'h00, "read before latch");
    w = 0;
    while (done !== 1'b1 && w < 24000)
    begin
      @(negedge ref_clk);
      w++;
    end
    chk(done === 1'b1, "setting period did not end");
  endtask

  // pins quiet and one source at a time while setting; no conversion afterwards
  always @(posedge ref_clk)
  begin
    if (!rst && done === 1'b0 && (ph_oe !== 7'h00 || src[8] !== 1'b0 || !$onehot0(src)))
      chk(1'b0, "phase pin or source misused during setting");
    if (done === 1'b1 && adc_start !== 1'b0)
      chk(1'b0, "conversion after results latched");
  end

  // watchdog sized for four setting periods plus margin
  initial
  begin
    cyc(95000);
    chk(1'b0, "watchdog expired");
    stop_test();
  end

  initial
  begin
    // prompt converter, every phase present, 4+3 group
    run_setting({9'h078, 9'h01f, 9'h0e8, 9'h018, 9'h064, 9'h032, 9'h064, 9'h03c, 9'h00a},
                7'h00, 7'h7f);
    chk(gfx_max === 8'h3c && core_max === 8'h64, "max-current codes");
    chk(ontime === 16'h1388 && ocp === 1'b0 && vin_code === 8'h78, "on-time");
    chk(phase_cfg === CFG_4P3 && dev_addr === ADDR_LO, "config and address");
    chk(core_en === 4'hf && gfx_en === 3'h7, "all phases active");
    chk(boot_1v05 === 1'b1 && core_ext === 1'b1 && gfx_ext === 1'b0, "boot code");
    chk(core_bst === 8'h0f && gfx_bst === 8'hd2, "boost end points");
    // ready is timed from the latch edge, so count before the reads use up cycles
    k = 0;
    while (ready !== 1'b1 && k < 100)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk(k >= RDY - 4 && k <= RDY + 4 && drv_en === 1'b1, "ready delay");
    reg_read(1'b0, REG_MAX_CUR, 8'h64, "core register");
    reg_read(1'b1, REG_MAX_CUR, 8'h3c, "graphics register");
    reg_read(1'b0, 8'h22, 8'h00, "unmapped index");
    @(posedge ref_clk);
    pwm_in <= 7'h55;
    cyc(3);
    #1 chk(ph_out === 7'h55 && ph_oe === 7'h7f, "pulses reach pins");
    @(posedge ref_clk);
    en_in  <= 1'b0;
    straps <= '0;
    neg_s  <= 7'h7f;
    cyc(6);
    #1 chk(ready === 1'b0 && drv_en === 1'b0, "ready drop");
    chk(core_en === 4'hf && core_max === 8'h64, "results frozen");
    $display("test basic done");
    // slow converter, over-range straps, 6+1 selection
    @(posedge ref_clk);
    delay <= 4'h7;
    run_setting({9'h060, 9'h12c, 9'h038, 9'h078, 9'h064, 9'h0c8, 9'h100, 9'h12c, 9'h014},
                7'h10, 7'h7f);
    chk(gfx_max === CODE_FULL && core_max === CODE_FULL, "over-range");
    chk(ontime === 16'h4e20 && ocp === 1'b1, "current-limit band");
    chk(phase_cfg === CFG_6P1 && dev_addr === ADDR_LO, "six plus one");
    chk(boot_1v05 === 1'b0 && core_ext === 1'b0 && gfx_ext === 1'b0, "open boot");
    chk(core_bst === 8'h69 && gfx_bst === 8'h2d, "mid boost");
    reg_read(1'b1, REG_MAX_CUR, CODE_FULL, "saturated register");
    $display("test over-range done");
    // 4+2 with every core phase disabled, boot strap on the sense pin
    @(posedge ref_clk);
    delay    <= 4'h3;
    alt_boot <= 9'h085;
    run_setting({9'h000, 9'h010, 9'h0a9, 9'h0c8, 9'h0ae, 9'h011, 9'h0ff, 9'h000, 9'h00a},
                7'h4f, 7'h30);
    chk(phase_cfg === CFG_4P2 && dev_addr === ADDR_HI, "four plus two");
    chk(core_en === 4'h1 && gfx_en === 3'h3, "disabled phases");
    chk(boot_1v05 === 1'b0 && core_ext === 1'b1 && gfx_ext === 1'b0, "boot pin");
    chk(core_max === 8'hff && gfx_max === 8'h00 && ontime === 16'h06a4, "range ends");
    chk(core_bst === 8'hb4 && gfx_bst === 8'h96, "boost steps");
    @(posedge ref_clk);
    pwm_in <= 7'h7f;
    cyc(3);
    #1 chk(ph_oe === 7'h71 && ph_out === 7'h31, "enable pin low");
    @(posedge ref_clk);
    en_in <= 1'b1;
    cyc(RDY + 10);
    #1 chk(ph_out === 7'h71 && drv_en === 1'b1, "enable pin high");
    $display("test four plus two done");
    // 20k group without the 6+1 pin, address strap just above the narrow split
    run_setting({9'h060, 9'h014, 9'h018, 9'h018, 9'h01f, 9'h032, 9'h010, 9'h020, 9'h014},
                7'h00, 7'h7f);
    chk(phase_cfg === CFG_5P2 && dev_addr === ADDR_HI, "five plus two");
    chk(vin_code === 8'h60 && ocp === 1'b0 && core_max === 8'h10, "five plus two codes");
    $display("test five plus two done");
    stop_test();
  end
endmodule
`default_nettype wire

// ### verilog/slp_band_decode.sv
`timescale 1ns/10ps
`default_nettype none
module slp_band_decode
#(
  parameter int N = 7,
  parameter int W = 3,
  parameter logic [N*8-1:0] THR = '0
)
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // strap code in, band index out
  input  wire logic [7:0]   code,
  output logic      [W-1:0] band
);
  import slp_pkg::*;

  logic [N-1:0] above;

  // count of thresholds passed, thresholds ascend
  function automatic logic [W-1:0] ones(input logic [N-1:0] v);
    logic [W-1:0] s;
    s = '0;
    for (int i = 0; i < N; i++)
    begin
      s = s + W'(v[i]);
    end
    return s;
  endfunction

  // one comparator per band edge
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_cmp
      assign above[g] = code > THR[g*8 +: 8];
    end
  endgenerate

  // registered so the band lands one cycle after the code
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      band <= '0;
    else
      band <= ones(above);
  end
endmodule
`default_nettype wire

// ### verilog/slp_strap_loader.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1 - each strap pin gets a 10uA source only while its channel settles and is converted
// R2 - graphics max-current strap converted to 8-bit code, 10mV per code
// R3 - core max-current strap on core phase three, readable at index 0x21
// R4 - converter over-range stores FFh instead of wrapping
// R5 - max-current codes are reported only, never feed protection
// R6 - shared on-time factor is strap kilohms times 100, with input voltage code
// R7 - phase-four strap low band means latch-off, high band current-limit
// R8 - driver-enable strap 10k picks 4+3 or 4+2, 20k picks 5+2 or 6+1
// R9 - driver-enable and graphics phase-two straps choose address 88h or 8Ah
// R10 - 6+1 needs the 20k group and graphics phase-one negative pin high
// R11 - in 4+2 the boot strap is read from graphics phase-three positive sense
// R12 - in 4+2 graphics phase-three output follows driver enable
// R13 - boot strap gives eight codes: boot voltage and two extension enables
// R14 - after reset a phase with negative high and positive low is disabled
// R15 - up to four core and three graphics phases, each removable
// R16 - each rail keeps at least one active phase
// R17 - phase-one straps give 14 boost steps, 15 to 210 mV, per rail
// R18 - attached drivers keep phase inputs high impedance while disabled
// R19 - disabled graphics phase pins are never driven and may float; the code drives graphics phase three in 4+2
// R20 - ready rises a delay below 2.5ms after enable with supplies valid
// R21 - decoded results latch once at end of setting, held until reset
// R22 - phase outputs stay undriven until the setting period is over
module slp_strap_loader
#(
  parameter int unsigned RDY_CYC = slp_pkg::RDY_DELAY_US * slp_pkg::CLK_MHZ
)
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // enable and supply-valid pins
  input  wire logic                     en_in,
  input  wire logic                     supply_ok,
  // strap converter, same clock
  output logic                          adc_start,
  output logic      [3:0]               adc_chan,
  input  wire logic                     adc_done,
  input  wire logic [7:0]               adc_code,
  input  wire logic                     adc_over,
  output logic      [8:0]               cur_src_on,
  output logic                          boot_from_pos_sense,
  // phase sense pins
  input  wire logic [6:0]               phase_neg_sense,
  input  wire logic [6:0]               phase_pos_sense,
  // phase pins, core 1-4 then graphics 1-3
  input  wire logic [6:0]               pwm_in,
  output logic      [6:0]               phase_strap_out,
  output logic      [6:0]               phase_strap_oe,
  output logic                          driver_enable_out,
  output logic                          regulator_ready,
  // decoded configuration
  output logic                          straps_done,
  output logic      [7:0]               core_max_cur,
  output logic      [7:0]               gfx_max_cur,
  output logic      [15:0]              ontime_kohm_x100,
  output logic      [7:0]               vin_code,
  output logic                          ocp_current_limit,
  output logic      [7:0]               dev_addr,
  output var slp_pkg::slp_cfg_e         phase_cfg,
  output logic      [3:0]               core_ph_en,
  output logic      [2:0]               gfx_ph_en,
  output logic                          boot_1v05,
  output logic                          core_ext_en,
  output logic                          gfx_ext_en,
  output logic      [7:0]               core_boost_mv,
  output logic      [7:0]               gfx_boost_mv,
  // max-current register read port
  input  wire logic                     reg_rd,
  input  wire logic                     reg_rail,
  input  wire logic [7:0]               reg_addr,
  output logic                          reg_ack,
  output logic      [7:0]               reg_rdata
);
  import slp_pkg::*;

  localparam int RDY_W = $clog2(RDY_CYC + 1);
  localparam logic [RDY_W-1:0] RDY_LAST = RDY_W'(RDY_CYC - 1);
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(NCH - 1);

  logic [NPH-1:0] neg_m_ff;
  logic [NPH-1:0] neg_s_ff;
  logic [NPH-1:0] pos_m_ff;
  logic [NPH-1:0] pos_s_ff;
  logic [1:0]     lvl_m_ff;
  logic [1:0]     lvl_s_ff;
  slp_state_e     st_ff;
  slp_state_e     nxt_st;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CH_W-1:0] ch_ff;
  logic [CH_W-1:0] nxt_ch;
  logic [7:0]     res_ff [NCH];
  logic [NPH-1:0] dis_ff;
  logic           six_one_ff;
  logic           done_ff;
  logic           held_ff;
  logic [RDY_W-1:0] rdy_cnt_ff;
  logic           rdy_ff;
  logic [2:0]     boot_band;
  logic [3:0]     boost_core_band;
  logic [3:0]     boost_gfx_band;

  // pins are asynchronous, two flops before any use
  always_ff @(posedge ref_clk)
  begin
    neg_m_ff <= phase_neg_sense;
    neg_s_ff <= neg_m_ff;
    pos_m_ff <= phase_pos_sense;
    pos_s_ff <= pos_m_ff;
    lvl_m_ff <= {supply_ok, en_in};
    lvl_s_ff <= lvl_m_ff;
  end

  // sequencer decodes
  wire       settle_end = cnt_ff == SETTLE_LAST;
  wire       sync_end   = cnt_ff == SYNC_LAST;
  wire       conv_take  = (st_ff == ST_WAIT) && adc_done;
  wire       last_ch    = ch_ff == CH_LAST;
  wire [7:0] conv_val   = adc_over ? CODE_FULL : adc_code; // R4
  wire       run_ok     = done_ff && lvl_s_ff[0] && lvl_s_ff[1];

  // next state: one settle, one start pulse, one wait per channel
  always_comb
  begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ch  = ch_ff;
    case (st_ff)
      ST_SYNC:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (sync_end)
          nxt_st = ST_SENSE;
      end
      ST_SENSE:
      begin
        nxt_cnt = '0;
        nxt_st  = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (settle_end)
          nxt_st = ST_CONV;
      end
      ST_CONV:
        nxt_st = ST_WAIT;
      ST_WAIT:
      begin
        if (adc_done)
        begin
          nxt_cnt = '0;
          nxt_st  = last_ch ? ST_DONE : ST_SETTLE;
          nxt_ch  = last_ch ? ch_ff : ch_ff + 1'b1;
        end
      end
      ST_DONE:
        nxt_st = ST_DONE;
      default:
        nxt_st = ST_SYNC;
    endcase
  end

  // sequencer registers; reset restarts the whole setting period
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_ff   <= ST_SYNC;
      cnt_ff  <= '0;
      ch_ff   <= '0;
      done_ff <= 1'b0;
      held_ff <= 1'b0;
    end
    else
    begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      ch_ff   <= nxt_ch;
      done_ff <= nxt_st == ST_DONE;
      held_ff <= done_ff;
    end
  end

  // converter handshake and current sources; the input voltage channel has none
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      adc_start  <= 1'b0;
      cur_src_on <= '0;
    end
    else
    begin
      adc_start  <= nxt_st == ST_CONV;
      cur_src_on <= (nxt_st == ST_SETTLE || nxt_st == ST_CONV || nxt_st == ST_WAIT)
                    ? (NCH'(1) << nxt_ch) & SRC_MASK : '0; // R1
    end
  end
  assign adc_chan = ch_ff;

  // codes are stored only during the setting period // R21
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        res_ff[i] <= '0;
      end
    end
    else if (conv_take)
      res_ff[ch_ff] <= conv_val; // R2 R3
  end

  // phase presence is sampled once, after the synchronisers have filled
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dis_ff     <= '0;
      six_one_ff <= 1'b0;
    end
    else if (st_ff == ST_SENSE)
    begin
      dis_ff     <= neg_s_ff & ~pos_s_ff; // R14
      six_one_ff <= neg_s_ff[PIN_GFX1] & pos_s_ff[PIN_GFX1]; // R10
    end
  end

  // configuration decode from straps and sensed phases
  wire       grp43    = res_ff[CH_DRV] <= DRV_SPLIT; // R8
  wire       is_4p2   = grp43 && dis_ff[PIN_GFX3];
  wire [3:0] core_raw = ~dis_ff[3:0];
  wire [2:0] gfx_raw  = ~dis_ff[6:4];
  wire [3:0] core_w   = (|core_raw) ? core_raw : 4'h1; // R15 R16
  wire [2:0] gfx_w    = (|gfx_raw) ? gfx_raw : 3'h1; // R15 R16
  wire slp_cfg_e cfg_w = grp43 ? (is_4p2 ? CFG_4P2 : CFG_4P3)
                               : (six_one_ff ? CFG_6P1 : CFG_5P2); // R8 R10
  wire [7:0] addr_thr = (cfg_w == CFG_5P2) ? ADDR_52_SPLIT : ADDR_43_SPLIT;
  wire [7:0] addr_w   = (res_ff[CH_ADDR] > addr_thr) ? ADDR_HI : ADDR_LO; // R9
  wire       boot_lv  = boot_band <= 3'(BOOT_LV_MAX);
  wire       core_ext = boot_lv ? boot_band[1] : (boot_band == 3'h4 || boot_band == 3'h5);
  wire       gfx_ext  = boot_lv ? boot_band[0] : (boot_band == 3'h4 || boot_band == 3'h6);

  // the boot pin moves to positive sense in 4+2; known before its turn
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      boot_from_pos_sense <= 1'b0;
    else
      boot_from_pos_sense <= is_4p2; // R11
  end

  // band decoders for boot and boost straps
  slp_band_decode #(.N(7), .W(3), .THR(BOOT_THR)) u_boot
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .code    (res_ff[CH_BOOT]),
    .band    (boot_band)
  );
  slp_band_decode #(.N(13), .W(4), .THR(BOOST_THR)) u_boost_core
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .code    (res_ff[CH_BOOST_CORE]),
    .band    (boost_core_band)
  );
  slp_band_decode #(.N(13), .W(4), .THR(BOOST_THR)) u_boost_gfx
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .code    (res_ff[CH_BOOST_GFX]),
    .band    (boost_gfx_band)
  );

  // publish once when setting ends; max-current codes only go out as
  // register contents, nothing here reaches a protection threshold // R5
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      core_max_cur      <= '0;
      gfx_max_cur       <= '0;
      ontime_kohm_x100  <= '0;
      vin_code          <= '0;
      ocp_current_limit <= 1'b0;
      dev_addr          <= ADDR_LO;
      phase_cfg         <= CFG_4P3;
      core_ph_en        <= 4'h1;
      gfx_ph_en         <= 3'h1;
      boot_1v05         <= 1'b0;
      core_ext_en       <= 1'b0;
      gfx_ext_en        <= 1'b0;
      core_boost_mv     <= '0;
      gfx_boost_mv      <= '0;
    end
    else if (done_ff && !held_ff) // R21
    begin
      core_max_cur      <= res_ff[CH_CORE_IMAX]; // R3
      gfx_max_cur       <= res_ff[CH_GFX_IMAX]; // R2
      ontime_kohm_x100  <= 16'(res_ff[CH_ONTIME] * ONTIME_SCALE); // R6
      vin_code          <= res_ff[CH_VIN]; // R6
      ocp_current_limit <= res_ff[CH_ONTIME] > LATCH_BAND_MAX; // R7
      dev_addr          <= addr_w;
      phase_cfg         <= cfg_w;
      core_ph_en        <= core_w;
      gfx_ph_en         <= gfx_w;
      boot_1v05         <= boot_lv; // R13
      core_ext_en       <= core_ext; // R13
      gfx_ext_en        <= gfx_ext; // R13
      core_boost_mv     <= 8'((boost_core_band + 1) * BOOST_STEP_MV); // R17
      gfx_boost_mv      <= 8'((boost_gfx_band + 1) * BOOST_STEP_MV); // R17
    end
  end
  assign straps_done = held_ff;

  // start-up delay; dropping enable or supply restarts it
  always_ff @(posedge ref_clk)
  begin
    if (rst || !run_ok || !held_ff)
    begin
      rdy_cnt_ff <= '0;
      rdy_ff     <= 1'b0;
    end
    else if (rdy_cnt_ff == RDY_LAST)
      rdy_ff <= 1'b1; // R20
    else
      rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
  end
  assign regulator_ready   = rdy_ff;
  assign driver_enable_out = rdy_ff; // drivers stay off, so their inputs stay high-z // R18

  // phase pins: undriven during setting, disabled phases left floating except graphics phase three in 4+2
  wire [NPH-1:0] ph_en = {gfx_ph_en, core_ph_en};
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_strap_out <= '0;
      phase_strap_oe  <= '0;
    end
    else
    begin
      phase_strap_out <= held_ff ? (pwm_in & ph_en) : '0; // R22
      phase_strap_oe  <= held_ff ? ph_en : '0; // R19 R22
      if (held_ff && phase_cfg == CFG_4P2)
      begin
        phase_strap_out[PIN_GFX3] <= rdy_ff; // R12
        phase_strap_oe[PIN_GFX3]  <= 1'b1; // R12
      end
    end
  end

  // register read: one-cycle answer, unmapped index reads zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_ack   <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      reg_ack   <= reg_rd;
      reg_rdata <= (reg_rd && reg_addr == REG_MAX_CUR)
                   ? (reg_rail ? gfx_max_cur : core_max_cur) : '0; // R2 R3
    end
  end

  a_setting_hiz: assert property (@(posedge ref_clk) disable iff (rst) // R22
    !held_ff |=> phase_strap_oe == '0)
    else $error("phase pin driven during setting");
  a_src_window: assert property (@(posedge ref_clk) disable iff (rst) // R1
    cur_src_on != '0 |-> !done_ff && $onehot(cur_src_on))
    else $error("current source outside its window");
  a_sat_full: assert property (@(posedge ref_clk) disable iff (rst) // R4
    conv_take && adc_over && ch_ff == CH_CORE_IMAX |=> res_ff[CH_CORE_IMAX] == CODE_FULL)
    else $error("over-range code not saturated");
  a_hold_results: assert property (@(posedge ref_clk) disable iff (rst) // R21
    held_ff && $past(held_ff) |-> $stable(dev_addr) && $stable(core_max_cur))
    else $error("latched result changed");
  a_min_phase: assert property (@(posedge ref_clk) disable iff (rst) // R16
    held_ff |-> core_ph_en != '0 && gfx_ph_en != '0)
    else $error("rail with no active phase");
  a_gfx3_follow: assert property (@(posedge ref_clk) disable iff (rst) // R12
    held_ff && phase_cfg == CFG_4P2 ##1 held_ff
      |-> phase_strap_out[PIN_GFX3] == $past(driver_enable_out) && phase_strap_oe[PIN_GFX3])
    else $error("phase three not following driver enable");
  a_addr_legal: assert property (@(posedge ref_clk) disable iff (rst) // R9
    held_ff |-> dev_addr == ADDR_LO || dev_addr == ADDR_HI)
    else $error("illegal bus address");
  a_ready_delay: assert property (@(posedge ref_clk) disable iff (rst) // R20
    $rose(regulator_ready) |-> $past(rdy_cnt_ff) == RDY_LAST && $past(run_ok))
    else $error("ready without full delay");
  a_boot_pin: assert property (@(posedge ref_clk) disable iff (rst) // R11
    st_ff == ST_CONV && ch_ff == CH_BOOT |-> boot_from_pos_sense == is_4p2)
    else $error("boot strap read from wrong pin");
  a_reg_read: assert property (@(posedge ref_clk) disable iff (rst) // R3
    reg_rd && reg_addr == REG_MAX_CUR && !reg_rail
      |=> reg_ack && reg_rdata == $past(core_max_cur))
    else $error("max-current read mismatch");
endmodule
`default_nettype wire
